// ### common/acf_defs.svh
`ifndef ACF_DEFS_SVH
`define ACF_DEFS_SVH

`define ACF_NSLOT      12
`define ACF_SLOT_W     4
`define ACF_RES_W      12
`define ACF_DATA_W     32
`define ACF_ADDR_W     12
`define ACF_IDX_W      6
`define ACF_IDX_LSB    2
`define ACF_IDX_MSB    7
`define ACF_NEV        3

`define ACF_IDX_PER_SLOT_COMPARE_ON   6'h08
`define ACF_IDX_STAT   6'h0a
`define ACF_IDX_DIEN   6'h0c
`define ACF_IDX_GREATER_THAN_SELECT_ALT  6'h0e
`define ACF_IDX_RES0   6'h10
`define ACF_IDX_RESL   6'h26
`define ACF_RES_STRIDE 2
`define ACF_IDX_ISTAT  6'h28
`define ACF_IDX_IMASK  6'h2a

`define ACF_EV_DONE    0
`define ACF_EV_CMP     1
`define ACF_EV_ABORT   2

`endif

// ### common/acf_pkg.sv
`include "acf_defs.svh"

package acf_pkg;

  typedef struct packed {
    logic                    valid;
    logic [`ACF_SLOT_W-1:0]  slot;
    logic [`ACF_RES_W-1:0]   value;
  } acf_conv_t;

  typedef struct packed {
    logic [`ACF_IDX_W-1:0]   index;
    logic                    hit;
    logic                    cap;
    logic                    wr;
    logic                    rd;
    logic [`ACF_DATA_W-1:0]  wdata;
  } acf_bus_req_t;

  typedef enum logic {
    ACF_IDLE = 1'b0,
    ACF_ANS  = 1'b1
  } acf_phase_t;

  typedef struct packed {
    acf_phase_t              phase;
    logic                    err;
  } acf_apb_state_t;

  typedef struct packed {
    logic [`ACF_NSLOT-1:0]                    cmp_en;
    logic [`ACF_NSLOT-1:0]                    cmp_gt;
    logic [`ACF_NSLOT-1:0]                    din_en;
    logic [`ACF_NSLOT-1:0]                    flags;
    logic [`ACF_NSLOT-1:0][`ACF_RES_W-1:0]    res;
    logic [`ACF_NEV-1:0]                      istat;
    logic [`ACF_NEV-1:0]                      imask;
    logic [`ACF_DATA_W-1:0]                   rdata;
    logic                                     abort;
    logic                                     cirq;
    logic                                     irq;
  } acf_core_t;

endpackage

// ### hw/acf_slot_compare.sv
`timescale 1ns/1ns

module acf_slot_compare
  import acf_pkg::*;
(
  input  wire logic [`ACF_RES_W-1:0] result,
  input  wire logic [`ACF_RES_W-1:0] ref_value,
  input  wire logic                  gt_sel,
  output logic                       is_true
);

  assign is_true = gt_sel ? (result > ref_value) : (result <= ref_value);

endmodule

// ### hw/acf_apb_slave.sv
`timescale 1ns/1ns

module acf_apb_slave
  import acf_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`ACF_ADDR_W-1:0] paddr,
  input  wire logic [`ACF_DATA_W-1:0] pwdata,
  output logic                        pready,
  output logic                        pslverr,
  output acf_bus_req_t                req
);

  acf_apb_state_t        st;
  acf_apb_state_t        next_st;
  logic [`ACF_IDX_W-1:0] idx;
  logic                  in_res;
  logic                  hit;

  assign idx    = paddr[`ACF_IDX_MSB:`ACF_IDX_LSB];
  assign in_res = (idx >= `ACF_IDX_RES0) && (idx <= `ACF_IDX_RESL) && !idx[0];

  // Only word-aligned addresses of listed registers are mapped.
  always_comb begin
    hit = 1'b0;
    if ((paddr[`ACF_ADDR_W-1:`ACF_IDX_MSB+1] == '0) && (paddr[`ACF_IDX_LSB-1:0] == '0)) begin
      unique case (idx)
        `ACF_IDX_PER_SLOT_COMPARE_ON, `ACF_IDX_STAT, `ACF_IDX_DIEN, `ACF_IDX_GREATER_THAN_SELECT_ALT,
        `ACF_IDX_ISTAT, `ACF_IDX_IMASK: hit = 1'b1;
        default: hit = in_res;
      endcase
    end
  end

  // One wait state: the answer comes in the second access cycle.
  always_comb begin
    next_st = st;
    unique case (st.phase)
      ACF_IDLE: begin
        if (psel && penable) begin
          next_st.phase = ACF_ANS;
          next_st.err   = !hit;
        end
      end
      ACF_ANS: begin
        next_st.phase = ACF_IDLE;
        next_st.err   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign pready    = (st.phase == ACF_ANS);
  assign pslverr   = st.err;
  assign req.index = idx;
  assign req.hit   = hit;
  assign req.cap   = (st.phase == ACF_IDLE) && psel && penable;
  assign req.wr    = pready && psel && penable && pwrite && hit;
  assign req.rd    = pready && psel && penable && !pwrite && hit;
  assign req.wdata = pwdata;

endmodule

// ### hw/acf_flags.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns

// Behaviour
// - compare enable write aborts running sequence.
// - twelve compare enables, one per slot.
// - operator bit per slot picks direction.
// - bit 0 lower-or-same, 1 strictly higher.
// - slot n sets done flag n.
// - compare slot flags only when true; irq.
// - compare slot keeps value, drops result.
// - sequence start clears all done flags.
// - normal mode: write one clears flag.
// - fast mode, no compare: read clears.
// - fast mode, compare: result write clears.
// - start beats set; other clears lose.
// - status register ignores writes of zero.
// - twelve pin digital buffer enables.
module acf_flags
  import acf_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`ACF_ADDR_W-1:0] paddr,
  input  wire logic [`ACF_DATA_W-1:0] pwdata,
  output logic [`ACF_DATA_W-1:0]      prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire acf_conv_t              conv,
  input  wire logic                   seq_start,
  input  wire logic                   fast_flag_clear,
  input  wire logic                   compare_irq_enable,
  output logic                        seq_abort,
  output logic [`ACF_NSLOT-1:0]       pin_buffer_on,
  output logic                        compare_irq,
  output logic                        irq
);

  acf_bus_req_t                          req;
  acf_core_t                             st;
  acf_core_t                             next_st;
  logic [`ACF_NSLOT-1:0]                 cmp_true;
  logic [`ACF_NSLOT-1:0]                 slot_hit;
  logic [`ACF_NSLOT-1:0]                 flag_set;
  logic [`ACF_NSLOT-1:0]                 flag_clr;
  logic [`ACF_NSLOT-1:0]                 res_wr;
  logic [`ACF_NSLOT-1:0]                 res_rd;
  logic [`ACF_NSLOT-1:0]                 next_flags;
  logic [`ACF_NSLOT-1:0][`ACF_RES_W-1:0] next_res;
  logic [`ACF_NSLOT-1:0]                 res_sel;
  logic [`ACF_RES_W-1:0]                 rd_res;
  logic [`ACF_NEV-1:0]                   events;
  logic                                  wr_per_slot_compare_on;
  logic                                  wr_stat;
  logic                                  wr_dien;
  logic                                  wr_greater_than_select_alt;
  logic                                  wr_istat;
  logic                                  wr_imask;

  acf_apb_slave u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .pslverr (pslverr),
    .req     (req)
  );

  assign wr_per_slot_compare_on  = req.wr && (req.index == `ACF_IDX_PER_SLOT_COMPARE_ON);
  assign wr_stat  = req.wr && (req.index == `ACF_IDX_STAT);
  assign wr_dien  = req.wr && (req.index == `ACF_IDX_DIEN);
  assign wr_greater_than_select_alt = req.wr && (req.index == `ACF_IDX_GREATER_THAN_SELECT_ALT);
  assign wr_istat = req.wr && (req.index == `ACF_IDX_ISTAT);
  assign wr_imask = req.wr && (req.index == `ACF_IDX_IMASK);

  genvar i;
  generate
    for (i = 0; i < `ACF_NSLOT; i++) begin : g_slot
      localparam logic [`ACF_IDX_W-1:0] RIDX =
        `ACF_IDX_W'(`ACF_IDX_RES0 + `ACF_RES_STRIDE * i);
      localparam logic [`ACF_SLOT_W-1:0] SLOT = `ACF_SLOT_W'(i);

      acf_slot_compare u_cmp (
        .result    (conv.value),
        .ref_value (st.res[i]),
        .gt_sel    (st.cmp_gt[i]),
        .is_true   (cmp_true[i])
      );

      assign res_sel[i]  = (req.index == RIDX);
      assign res_wr[i]   = req.wr && res_sel[i];
      assign res_rd[i]   = req.rd && res_sel[i];
      assign slot_hit[i] = conv.valid && (conv.slot == SLOT);
      assign flag_set[i] = slot_hit[i] && (!st.cmp_en[i] || cmp_true[i]);

      assign flag_clr[i] = (wr_stat && !fast_flag_clear && req.wdata[i]) ||
                           (res_rd[i] && fast_flag_clear && !st.cmp_en[i]) ||
                           (res_wr[i] && fast_flag_clear && st.cmp_en[i]);

      always_comb begin
        if (seq_start) begin
          next_flags[i] = 1'b0;
        end else if (flag_set[i]) begin
          next_flags[i] = 1'b1;
        end else if (flag_clr[i]) begin
          next_flags[i] = 1'b0;
        end else begin
          next_flags[i] = st.flags[i];
        end
      end

      always_comb begin
        if (slot_hit[i] && !st.cmp_en[i]) begin
          next_res[i] = conv.value;
        end else if (res_wr[i]) begin
          next_res[i] = req.wdata[`ACF_RES_W-1:0];
        end else begin
          next_res[i] = st.res[i];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_res = '0;
    for (int k = 0; k < `ACF_NSLOT; k++) begin
      if (res_sel[k]) begin
        rd_res = st.res[k];
      end
    end
  end

  always_comb begin
    events                 = '0;
    events[`ACF_EV_DONE]   = |(flag_set & ~st.cmp_en);
    events[`ACF_EV_CMP]    = |(flag_set & st.cmp_en);
    events[`ACF_EV_ABORT]  = wr_per_slot_compare_on || wr_greater_than_select_alt;
  end

  always_comb begin
    next_st       = st;
    next_st.flags = next_flags;
    next_st.res   = next_res;

    if (wr_per_slot_compare_on) begin
      next_st.cmp_en = req.wdata[`ACF_NSLOT-1:0];
    end
    if (wr_greater_than_select_alt) begin
      next_st.cmp_gt = req.wdata[`ACF_NSLOT-1:0];
    end
    if (wr_dien) begin
      next_st.din_en = req.wdata[`ACF_NSLOT-1:0];
    end
    if (wr_imask) begin
      next_st.imask = req.wdata[`ACF_NEV-1:0];
    end

    // New events win over a clearing write of one.
    if (wr_istat) begin
      next_st.istat = (st.istat & ~req.wdata[`ACF_NEV-1:0]) | events;
    end else begin
      next_st.istat = st.istat | events;
    end

    next_st.abort = wr_per_slot_compare_on || wr_greater_than_select_alt;

    next_st.cirq = compare_irq_enable && |(next_st.flags & next_st.cmp_en);
    next_st.irq  = |(next_st.istat & next_st.imask);

    if (req.cap) begin
      next_st.rdata = '0;
      // Unmapped or misaligned reads return zero.
      if (req.hit) begin
        unique case (req.index)
          `ACF_IDX_PER_SLOT_COMPARE_ON:  next_st.rdata[`ACF_NSLOT-1:0] = st.cmp_en;
          `ACF_IDX_STAT:  next_st.rdata[`ACF_NSLOT-1:0] = st.flags;
          `ACF_IDX_DIEN:  next_st.rdata[`ACF_NSLOT-1:0] = st.din_en;
          `ACF_IDX_GREATER_THAN_SELECT_ALT: next_st.rdata[`ACF_NSLOT-1:0] = st.cmp_gt;
          `ACF_IDX_ISTAT: next_st.rdata[`ACF_NEV-1:0]   = st.istat;
          `ACF_IDX_IMASK: next_st.rdata[`ACF_NEV-1:0]   = st.imask;
          default:        next_st.rdata[`ACF_RES_W-1:0] = rd_res;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign prdata        = st.rdata;
  assign seq_abort     = st.abort;
  assign pin_buffer_on = st.din_en;
  assign compare_irq   = st.cirq;
  assign irq           = st.irq;

endmodule

// ### dv/acf_flags_sva.sv
`timescale 1ns/1ns

module acf_flags_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        seq_start,
  input wire logic        compare_irq_enable,
  input wire logic        seq_abort,
  input wire logic [11:0] pin_buffer_on,
  input wire logic        compare_irq
);
  wire logic wr_done = psel && penable && pready && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy_lat;
    $rose(psel && penable) |-> !pready ##1 pready;
  endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("bus answer late");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  property p_unmapped;
    psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("misaligned not refused");
  property p_abort_per_slot_compare_on;
    wr_done && paddr == 12'h020 |=> seq_abort;
  endproperty
  a_abort_per_slot_compare_on: assert property (p_abort_per_slot_compare_on) else $error("no abort");
  property p_abort_cause;
    seq_abort |-> $past(wr_done) && ($past(paddr) == 12'h020 || $past(paddr) == 12'h038);
  endproperty
  a_abort_cause: assert property (p_abort_cause) else $error("stray abort");
  property p_abort_pulse;
    seq_abort |=> !seq_abort;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort too long");
  property p_pin_buf;
    wr_done && paddr == 12'h030 |=> pin_buffer_on == $past(pwdata[11:0]);
  endproperty
  a_pin_buf: assert property (p_pin_buf) else $error("buffer enables wrong");
  property p_pin_hold;
    !(wr_done && paddr == 12'h030) |=> $stable(pin_buffer_on);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("buffer enables moved");
  property p_cirq_en;
    compare_irq |-> $past(compare_irq_enable);
  endproperty
  a_cirq_en: assert property (p_cirq_en) else $error("irq while disabled");
  property p_start_clr;
    seq_start && ce |-> ##1 !compare_irq;
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("irq after start");
  property p_freeze;
    !ce |=> $stable(pin_buffer_on) && $stable(compare_irq) && $stable(seq_abort) && $stable(pready);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

bind acf_flags acf_flags_sva u_acf_flags_sva (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .seq_start, .compare_irq_enable, .seq_abort,
  .pin_buffer_on, .compare_irq);

// ### dv/tb.sv
`timescale 1ns/1ns

module tb;
  import acf_pkg::*;
  logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0, m_per_slot_compare_on = 0, m_gt = 0, m_dien = 0, m_flg = 0, pin_buffer_on;
  logic [31:0] pwdata = 0, prdata, rd, ex;
  logic        pready, pslverr, seq_start = 0, seq_abort, compare_irq, irq, er;
  logic        fast_flag_clear = 0, compare_irq_enable = 0;
  logic [2:0]  m_ist = 0, m_msk = 0;
  logic [11:0] m_res [12] = '{default: 0};
  acf_conv_t   conv = 0, cv;
  int          mismatches = 0, checks_done = 0, cycles = 0, seed = 61418, r, s, d;

  acf_flags u_acf_flags (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .conv, .seq_start, .fast_flag_clear, .compare_irq_enable,
    .seq_abort, .pin_buffer_on, .compare_irq, .irq);

  initial forever #4 pclk = ~pclk;

  task automatic give_verdict;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic hit(input acf_conv_t c);
    if (!m_per_slot_compare_on[c.slot]) return c.valid;
    return c.valid && (m_gt[c.slot] ? c.value > m_res[c.slot] : c.value <= m_res[c.slot]);
  endfunction

  // Sets win over bus clears; a start wins over sets.
  task automatic mconv(input acf_conv_t c, input logic h, input logic sc, input logic st);
    if (h && !st) m_flg[c.slot] = 1;
    if (h && sc) m_ist[1] = 1;
    if (c.valid && !sc) begin
      m_res[c.slot] = c.value;
      m_ist[0] = 1;
    end
  endtask

  task automatic op(input logic w, input logic [11:0] a, input logic [31:0] dt);
    logic h, sc, ok, bad;
    int n;
    if (!w) cv.valid = 0;
    h = hit(cv);
    sc = m_per_slot_compare_on[cv.slot];
    n = (a - 12'h040) >> 3;
    ok = a >= 12'h040 && a < 12'h0a0 && a[2:0] == 0;
    bad = 0;
    case (a)
      12'h020: ex = m_per_slot_compare_on;
      12'h028: ex = m_flg;
      12'h030: ex = m_dien;
      12'h038: ex = m_gt;
      12'h0a0: ex = m_ist;
      12'h0a8: ex = m_msk;
      default: begin
        ex = ok ? m_res[n] : 0;
        bad = !ok;
      end
    endcase
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    if (w) conv <= cv;
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    conv <= 0;
    chk(er, bad);
    if (!w) chk(rd, ex);
    if (w && !bad) case (a)
      12'h020: m_per_slot_compare_on = dt[11:0];
      12'h028: if (!fast_flag_clear) m_flg &= ~dt[11:0];
      12'h030: m_dien = dt[11:0];
      12'h038: m_gt = dt[11:0];
      12'h0a0: m_ist &= ~dt[2:0];
      12'h0a8: m_msk = dt[2:0];
      default: begin
        m_res[n] = dt[11:0];
        if (fast_flag_clear && m_per_slot_compare_on[n]) m_flg[n] = 0;
      end
    endcase
    if (!w && ok && fast_flag_clear && !m_per_slot_compare_on[n]) m_flg[n] = 0;
    if (w && (a == 12'h020 || a == 12'h038)) m_ist[2] = 1;
    mconv(cv, h, sc, 0);
    @(posedge pclk);
  endtask

  task automatic pulse(input logic st);
    logic h, sc;
    h = hit(cv);
    sc = m_per_slot_compare_on[cv.slot];
    seq_start <= st;
    conv <= cv;
    @(posedge pclk);
    seq_start <= 0;
    conv <= 0;
    if (st) m_flg = 0;
    mconv(cv, h, sc, st);
    @(posedge pclk);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk(pin_buffer_on, 0);
    repeat (700) begin
      r = $random(seed);
      d = $random(seed);
      s = r[7:4] % 12;
      cv = {r[31], 4'(s), r[27:16]};
      case (r[3:0])
        0, 1: op(r[30], 12'h020, d);
        2: op(r[30], 12'h028, d);
        3: op(r[30], 12'h030, d);
        4: op(r[30], 12'h038, d);
        10: op(r[30], 12'h0a0, d);
        11: op(r[30], 12'h0a8, d);
        12: op(r[30], r[9] ? 12'h102 : 12'h042, d);
        13: pulse(1);
        14: begin
          {fast_flag_clear, compare_irq_enable} <= r[9:8];
          @(posedge pclk);
          ce <= 0;
          seq_start <= 1;
          conv <= cv;
          @(posedge pclk);
          ce <= 1;
          seq_start <= 0;
          conv <= 0;
        end
        15: pulse(0);
        default: op(r[30], 12'h040 + 12'(s * 8), d);
      endcase
      repeat (2) @(posedge pclk);
      chk(compare_irq, compare_irq_enable & |(m_flg & m_per_slot_compare_on));
      chk(irq, |(m_ist & m_msk));
      chk(pin_buffer_on, m_dien);
      cv = 0;
      op(0, 12'h028, 0);
    end
    give_verdict;
  end
endmodule
